// File: design/vrb_top.sv
// vbi readback buffers, ready flags and output pin tri-state decision
`default_nettype none
// Behaviour
// R1: odd caption word at 0x22 low, 0x23 high
// R2: even caption word at 0x24 low, 0x25 high
// R3: odd copy word 0x26..0x28, nibble in 0x28
// R4: even copy word 0x29..0x2B, nibble in 0x2B
// R5: widescreen low 0x2C, five bits at 0x2D
// R6: format codes 656, mux8, sep16, rgb24
// R7: internal format bits only in register mode
// R8: control 00 floats chroma, blue unless rgb
// R9: control 01 floats luma, chroma, blue, aux high
// R10: control 10 floats data, sync, valid, status
// R11: host never programs control 11 in normal
// R12: sleep option 0: chroma/blue float, 16-bit blue only
// R13: sleep option 1 floats every listed pin
// R14: rgb sleep option 0 drives every pin
// R15: pins not floated stay actively driven
// R16: clamp start shifts eight pixels per code
// R17: ready flag sticks until host clears it
// R18: control field at 0x1E, resets to 00
// R19: undefined high bits read zero, buffer writes ignored
module vrb_top
  import vrb_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // register access from the serial control front end
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // slicer capture strobes and words
  input wire logic CAPTION_ODD_STORE_I,
  input wire logic [CAPTION_W-1:0] CAPTION_ODD_DATA_I,
  input wire logic CAPTION_EVEN_STORE_I,
  input wire logic [CAPTION_W-1:0] CAPTION_EVEN_DATA_I,
  input wire logic COPYGUARD_ODD_STORE_I,
  input wire logic [COPYGUARD_W-1:0] COPYGUARD_ODD_DATA_I,
  input wire logic COPYGUARD_EVEN_STORE_I,
  input wire logic [COPYGUARD_W-1:0] COPYGUARD_EVEN_DATA_I,
  input wire logic WIDESCREEN_STORE_I,
  input wire logic [WIDESCREEN_W-1:0] WIDESCREEN_DATA_I,
  // mode and power state
  input wire logic [1:0] MODE_PIN_I,
  input wire logic INTERNAL_REG_MODE_I,
  input wire logic [1:0] INTERNAL_FORMAT_SELECT_I,
  input wire logic SLEEP_I,
  input wire logic SLEEP_OUTPUT_OPTION_I,
  input wire logic [7:0] CLAMP_WINDOW_TRIM_I,
  // decoded results
  output logic [1:0] FORMAT_O,
  output logic [7:0] VBI_READY_FLAGS_O,
  output logic [7:0] CLAMP_START_SHIFT_O,
  // pin output enables, high while the pin is driven
  output logic LUMA_OE_O,
  output logic CHROMA_OE_O,
  output logic BLUE_OE_O,
  output logic AUX_HIGH_OE_O,
  output logic AUX_LOW_OE_O,
  output logic SYNC_OE_O,
  output logic VALID_OE_O,
  output logic STATUS_OE_O
);
  // mode pins come from the board, so they are synchronised first
  logic [1:0] mode_meta;
  logic [1:0] mode_sync;
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
    end else begin
      mode_meta <= MODE_PIN_I;
      mode_sync <= mode_meta;
    end
  end

  // write decode; buffers have no write path at all
  logic wr_tsc;
  logic wr_clear;
  assign wr_tsc = REG_WR_I && (REG_ADDR_I == OFS_TRISTATE_CTRL);
  assign wr_clear = REG_WR_I && (REG_ADDR_I == OFS_FLAG_CLEAR);

  // tri-state control register
  logic [1:0] tsc;
  logic [1:0] next_tsc;
  always_comb begin
    // R18: control field in low bits
    next_tsc = wr_tsc ? REG_WDATA_I[1:0] : tsc;
  end
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      tsc <= TRISTATE_CTRL_RESET;
    end else begin
      tsc <= next_tsc;
    end
  end

  // capture slots, each clear pulse lasts only the write cycle
  logic [CAPTION_W-1:0] cap_odd;
  logic [CAPTION_W-1:0] cap_even;
  logic [COPYGUARD_W-1:0] cg_odd;
  logic [COPYGUARD_W-1:0] cg_even;
  logic [WIDESCREEN_W-1:0] wss;
  logic rdy_cap_odd;
  logic rdy_cap_even;
  logic rdy_cg_odd;
  logic rdy_cg_even;
  logic rdy_wss;

  // R17: sticky ready flags
  vrb_capture_slot #(.WIDTH(CAPTION_W)) u_cap_odd (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .store_i(CAPTION_ODD_STORE_I),
    .data_i(CAPTION_ODD_DATA_I),
    .clear_i(wr_clear && REG_WDATA_I[FLAG_CAPTION_ODD]),
    .data_o(cap_odd),
    .ready_o(rdy_cap_odd)
  );
  vrb_capture_slot #(.WIDTH(CAPTION_W)) u_cap_even (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .store_i(CAPTION_EVEN_STORE_I),
    .data_i(CAPTION_EVEN_DATA_I),
    .clear_i(wr_clear && REG_WDATA_I[FLAG_CAPTION_EVEN]),
    .data_o(cap_even),
    .ready_o(rdy_cap_even)
  );
  vrb_capture_slot #(.WIDTH(COPYGUARD_W)) u_cg_odd (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .store_i(COPYGUARD_ODD_STORE_I),
    .data_i(COPYGUARD_ODD_DATA_I),
    .clear_i(wr_clear && REG_WDATA_I[FLAG_COPYGUARD_ODD]),
    .data_o(cg_odd),
    .ready_o(rdy_cg_odd)
  );
  vrb_capture_slot #(.WIDTH(COPYGUARD_W)) u_cg_even (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .store_i(COPYGUARD_EVEN_STORE_I),
    .data_i(COPYGUARD_EVEN_DATA_I),
    .clear_i(wr_clear && REG_WDATA_I[FLAG_COPYGUARD_EVEN]),
    .data_o(cg_even),
    .ready_o(rdy_cg_even)
  );
  vrb_capture_slot #(.WIDTH(WIDESCREEN_W)) u_wss (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .store_i(WIDESCREEN_STORE_I),
    .data_i(WIDESCREEN_DATA_I),
    .clear_i(wr_clear && REG_WDATA_I[FLAG_WIDESCREEN]),
    .data_o(wss),
    .ready_o(rdy_wss)
  );

  // flags owned elsewhere (stripe, agc) read as zero here
  logic [7:0] flags;
  always_comb begin
    flags = 8'h00;
    flags[FLAG_CAPTION_ODD] = rdy_cap_odd;
    flags[FLAG_CAPTION_EVEN] = rdy_cap_even;
    flags[FLAG_COPYGUARD_ODD] = rdy_cg_odd;
    flags[FLAG_COPYGUARD_EVEN] = rdy_cg_even;
    flags[FLAG_WIDESCREEN] = rdy_wss;
  end
  assign VBI_READY_FLAGS_O = flags;

  // read mux; unmapped and write-only offsets answer zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (REG_ADDR_I)
      OFS_READY_FLAGS: rd_mux = flags;
      // R1: odd caption bytes
      OFS_CAPTION_ODD_LOW: rd_mux = cap_odd[7:0];
      OFS_CAPTION_ODD_HIGH: rd_mux = cap_odd[15:8];
      // R2: even caption bytes
      OFS_CAPTION_EVEN_LOW: rd_mux = cap_even[7:0];
      OFS_CAPTION_EVEN_HIGH: rd_mux = cap_even[15:8];
      // R3: odd copy word
      OFS_COPYGUARD_ODD_B0: rd_mux = cg_odd[7:0];
      OFS_COPYGUARD_ODD_B1: rd_mux = cg_odd[15:8];
      // R19: undefined nibble zero
      OFS_COPYGUARD_ODD_B2: rd_mux = {4'h0, cg_odd[19:16]};
      // R4: even copy word
      OFS_COPYGUARD_EVEN_B0: rd_mux = cg_even[7:0];
      OFS_COPYGUARD_EVEN_B1: rd_mux = cg_even[15:8];
      OFS_COPYGUARD_EVEN_B2: rd_mux = {4'h0, cg_even[19:16]};
      // R5: widescreen bytes
      OFS_WIDESCREEN_LOW: rd_mux = wss[7:0];
      OFS_WIDESCREEN_HIGH: rd_mux = {3'h0, wss[12:8]};
      default: rd_mux = 8'h00;
    endcase
  end
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] next_rdata;
  logic next_rvalid;
  // read data held until the next read
  always_comb begin
    next_rdata = REG_RD_I ? rd_mux : rdata;
    next_rvalid = REG_RD_I;
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      rdata <= RDATA_RESET;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end
  assign REG_RDATA_O = rdata;
  assign REG_RVALID_O = rvalid;

  // R6: format codes from package
  vrb_format_t fmt;
  logic [1:0] next_fmt;
  logic next_luma;
  logic next_chroma;
  logic next_blue;
  logic next_aux_high;
  logic next_ctrl;
  logic [7:0] next_shift;

  always_comb begin
    // R7: register bits only in register mode
    next_fmt = INTERNAL_REG_MODE_I ? INTERNAL_FORMAT_SELECT_I : mode_sync;
    // R15: default is every pin driven
    next_luma = 1'b1;
    next_chroma = 1'b1;
    next_blue = 1'b1;
    next_aux_high = 1'b1;
    next_ctrl = 1'b1;
    if (SLEEP_I) begin
      if (SLEEP_OUTPUT_OPTION_I) begin
        // R13: sleep option floats all but aux low
        next_luma = 1'b0;
        next_chroma = 1'b0;
        next_blue = 1'b0;
        next_aux_high = 1'b0;
        next_ctrl = 1'b0;
      end else begin
        // R12: control ignored in sleep
        // R14: rgb keeps every pin
        unique case (vrb_format_t'(next_fmt))
          FMT_BT656, FMT_MUX8: begin
            next_chroma = 1'b0;
            next_blue = 1'b0;
          end
          FMT_SEP16: begin
            next_blue = 1'b0;
          end
          FMT_RGB24: begin
            next_blue = 1'b1;
          end
        endcase
      end
    end else begin
      unique case (vrb_tsc_t'(tsc))
        TSC_DATA_HIZ: begin
          // R9: data buses float
          next_luma = 1'b0;
          next_chroma = 1'b0;
          next_blue = 1'b0;
          next_aux_high = 1'b0;
        end
        TSC_ALL_HIZ: begin
          // R10: everything listed floats
          next_luma = 1'b0;
          next_chroma = 1'b0;
          next_blue = 1'b0;
          next_aux_high = 1'b0;
          next_ctrl = 1'b0;
        end
        TSC_ENABLE, TSC_UNDEFINED: begin
          // R8: rgb needs chroma and blue
          // the undefined code behaves as enable so pins never fight
          if (vrb_format_t'(next_fmt) != FMT_RGB24) begin
            next_chroma = 1'b0;
            next_blue = 1'b0;
          end
        end
      endcase
    end
    // R16: eight-pixel steps, c..f backwards
    next_shift = {CLAMP_WINDOW_TRIM_I[7:4] >= CLAMP_NEG_FIRST_CODE,
                  CLAMP_WINDOW_TRIM_I[7:4], 3'h0};
  end

  // enables registered so pins never glitch on a decode path
  logic luma_oe;
  logic chroma_oe;
  logic blue_oe;
  logic aux_high_oe;
  logic ctrl_oe;
  logic [7:0] shift;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      fmt <= FMT_BT656;
      luma_oe <= 1'b0;
      chroma_oe <= 1'b0;
      blue_oe <= 1'b0;
      aux_high_oe <= 1'b0;
      ctrl_oe <= 1'b0;
      shift <= 8'h00;
    end else begin
      fmt <= vrb_format_t'(next_fmt);
      luma_oe <= next_luma;
      chroma_oe <= next_chroma;
      blue_oe <= next_blue;
      aux_high_oe <= next_aux_high;
      ctrl_oe <= next_ctrl;
      shift <= next_shift;
    end
  end

  assign FORMAT_O = fmt;
  assign LUMA_OE_O = luma_oe;
  assign CHROMA_OE_O = chroma_oe;
  assign BLUE_OE_O = blue_oe;
  assign AUX_HIGH_OE_O = aux_high_oe;
  assign AUX_LOW_OE_O = 1'b1;
  assign SYNC_OE_O = ctrl_oe;
  assign VALID_OE_O = ctrl_oe;
  assign STATUS_OE_O = ctrl_oe;
  assign CLAMP_START_SHIFT_O = shift;
endmodule
`default_nettype wire

// File: design/vrb_pkg.sv
// shared constants for the vbi readback and output tri-state block
`default_nettype none
package vrb_pkg;
  // register offsets on the serial control subaddress space
  localparam logic [7:0] OFS_TRISTATE_CTRL = 8'h1E;
  localparam logic [7:0] OFS_FLAG_CLEAR = 8'h1F;
  localparam logic [7:0] OFS_READY_FLAGS = 8'h21;
  localparam logic [7:0] OFS_CAPTION_ODD_LOW = 8'h22;
  localparam logic [7:0] OFS_CAPTION_ODD_HIGH = 8'h23;
  localparam logic [7:0] OFS_CAPTION_EVEN_LOW = 8'h24;
  localparam logic [7:0] OFS_CAPTION_EVEN_HIGH = 8'h25;
  localparam logic [7:0] OFS_COPYGUARD_ODD_B0 = 8'h26;
  localparam logic [7:0] OFS_COPYGUARD_ODD_B1 = 8'h27;
  localparam logic [7:0] OFS_COPYGUARD_ODD_B2 = 8'h28;
  localparam logic [7:0] OFS_COPYGUARD_EVEN_B0 = 8'h29;
  localparam logic [7:0] OFS_COPYGUARD_EVEN_B1 = 8'h2A;
  localparam logic [7:0] OFS_COPYGUARD_EVEN_B2 = 8'h2B;
  localparam logic [7:0] OFS_WIDESCREEN_LOW = 8'h2C;
  localparam logic [7:0] OFS_WIDESCREEN_HIGH = 8'h2D;

  // bit positions inside the ready-flag and clear-request registers
  localparam int FLAG_CAPTION_ODD = 6;
  localparam int FLAG_CAPTION_EVEN = 5;
  localparam int FLAG_COPYGUARD_ODD = 4;
  localparam int FLAG_COPYGUARD_EVEN = 3;
  localparam int FLAG_WIDESCREEN = 0;

  // captured word widths
  localparam int CAPTION_W = 16;
  localparam int COPYGUARD_W = 20;
  localparam int WIDESCREEN_W = 13;

  // reset values
  localparam logic [1:0] TRISTATE_CTRL_RESET = 2'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // clamp trimmer: codes at or above this nibble shift backwards
  localparam logic [3:0] CLAMP_NEG_FIRST_CODE = 4'hC;

  // output format encodings
  typedef enum logic [1:0] {
    FMT_BT656 = 2'h0,
    FMT_MUX8 = 2'h1,
    FMT_SEP16 = 2'h2,
    FMT_RGB24 = 2'h3
  } vrb_format_t;

  // tri-state control encodings
  typedef enum logic [1:0] {
    TSC_ENABLE = 2'h0,
    TSC_DATA_HIZ = 2'h1,
    TSC_ALL_HIZ = 2'h2,
    TSC_UNDEFINED = 2'h3
  } vrb_tsc_t;
endpackage
`default_nettype wire

// File: design/vrb_capture_slot.sv
// one captured vbi word with its sticky ready flag
`default_nettype none
module vrb_capture_slot
  import vrb_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // capture side
  input wire logic store_i,
  input wire logic [WIDTH-1:0] data_i,
  // host side
  input wire logic clear_i,
  output logic [WIDTH-1:0] data_o,
  output logic ready_o
);
  logic [WIDTH-1:0] word;
  logic ready;
  logic [WIDTH-1:0] next_word;
  logic next_ready;

  // store a new word; a store in the clear cycle keeps the flag set
  always_comb begin
    next_word = store_i ? data_i : word;
    // R17: flag set wins
    next_ready = store_i | (ready & ~clear_i);
  end

  // buffer content has no documented reset value; zero keeps reads defined
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      word <= '0;
      ready <= 1'b0;
    end else begin
      word <= next_word;
      ready <= next_ready;
    end
  end

  assign data_o = word;
  assign ready_o = ready;
endmodule
`default_nettype wire

// File: tb/vrb_host.sv
// host controller model on the register port
`default_nettype none
module vrb_host
  import vrb_pkg::*;
(
  // clock and answer
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  // request
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port at time zero
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = (a == OFS_TRISTATE_CTRL && d[1:0] == TSC_UNDEFINED) ? 8'h00 : d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~wdata_o;
  endtask
  // strobe is a one-cycle pulse; the answer stands from the edge that takes it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rvalid_i ? rdata_i : 8'hxx;
  endtask
endmodule
`default_nettype wire

// File: tb/vrb_chk.sv
// concurrent checks on the top ports
`default_nettype none
module vrb_chk
  import vrb_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  // capture and mode
  input wire logic CAPTION_ODD_STORE_I,
  input wire logic INTERNAL_REG_MODE_I,
  input wire logic [1:0] INTERNAL_FORMAT_SELECT_I,
  input wire logic SLEEP_I,
  input wire logic SLEEP_OUTPUT_OPTION_I,
  input wire logic [7:0] CLAMP_WINDOW_TRIM_I,
  // results
  input wire logic [1:0] FORMAT_O,
  input wire logic [7:0] VBI_READY_FLAGS_O,
  input wire logic [7:0] CLAMP_START_SHIFT_O,
  input wire logic LUMA_OE_O,
  input wire logic CHROMA_OE_O,
  input wire logic BLUE_OE_O,
  input wire logic AUX_HIGH_OE_O,
  input wire logic AUX_LOW_OE_O,
  input wire logic SYNC_OE_O,
  input wire logic VALID_OE_O,
  input wire logic STATUS_OE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // helpers: clear request and trimmer code
  wire odd_clr = REG_WR_I && REG_ADDR_I == OFS_FLAG_CLEAR && REG_WDATA_I[FLAG_CAPTION_ODD];
  wire [3:0] trim_code = CLAMP_WINDOW_TRIM_I[7:4];
  wire all_off = !(LUMA_OE_O || CHROMA_OE_O || BLUE_OE_O || AUX_HIGH_OE_O || SYNC_OE_O);
  // reference shift in pixels, worked out by arithmetic rather than bit packing
  int trim_px;
  assign trim_px = (int'(trim_code) >= int'(CLAMP_NEG_FIRST_CODE)) ?
    int'(trim_code) * 8 - 128 : int'(trim_code) * 8;
  sequence ctrl_rd_s;
    REG_RD_I && REG_ADDR_I == OFS_TRISTATE_CTRL;
  endsequence
  sequence zero_ans_s;
    REG_RVALID_O && REG_RDATA_O == RDATA_RESET;
  endsequence
  sequence rgb_sleep_s;
    INTERNAL_REG_MODE_I && INTERNAL_FORMAT_SELECT_I == FMT_RGB24 &&
    SLEEP_I && !SLEEP_OUTPUT_OPTION_I;
  endsequence
  // back-to-back reads are legal, so each read is checked for its own answer
  rd_answer_a: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read answer missing");
  rd_idle_a: assert property (!REG_RD_I |=> !REG_RVALID_O)
    else $error("read answer without a read");
  ctrl_read_a: assert property (ctrl_rd_s |=> zero_ans_s)
    else $error("control place read not zero");
  aux_low_a: assert property (AUX_LOW_OE_O)
    else $error("aux low bits floated");
  sync_group_a: assert property (SYNC_OE_O == VALID_OE_O && VALID_OE_O == STATUS_OE_O &&
    (SYNC_OE_O || !LUMA_OE_O))
    else $error("sync valid status enables differ");
  int_format_a: assert property (INTERNAL_REG_MODE_I |=>
    FORMAT_O == $past(INTERNAL_FORMAT_SELECT_I))
    else $error("format not from internal bits");
  sleep_off_a: assert property (SLEEP_I && SLEEP_OUTPUT_OPTION_I |=> all_off)
    else $error("pin driven in sleep option one");
  rgb_sleep_a: assert property (rgb_sleep_s |=>
    LUMA_OE_O && CHROMA_OE_O && BLUE_OE_O && AUX_HIGH_OE_O && SYNC_OE_O)
    else $error("rgb sleep pin floated");
  clamp_step_a: assert property (1'b1 |=>
    int'($signed(CLAMP_START_SHIFT_O)) == $past(trim_px))
    else $error("clamp shift wrong");
  flag_set_a: assert property (CAPTION_ODD_STORE_I |=> VBI_READY_FLAGS_O[FLAG_CAPTION_ODD])
    else $error("ready flag not set");
  flag_hold_a: assert property (VBI_READY_FLAGS_O[FLAG_CAPTION_ODD] && !odd_clr |=>
    VBI_READY_FLAGS_O[FLAG_CAPTION_ODD])
    else $error("ready flag lost");
  flag_clear_a: assert property (odd_clr && !CAPTION_ODD_STORE_I |=>
    !VBI_READY_FLAGS_O[FLAG_CAPTION_ODD])
    else $error("ready flag not cleared");
endmodule
bind vrb_top vrb_chk chk_u (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
  .CAPTION_ODD_STORE_I(CAPTION_ODD_STORE_I), .INTERNAL_REG_MODE_I(INTERNAL_REG_MODE_I),
  .INTERNAL_FORMAT_SELECT_I(INTERNAL_FORMAT_SELECT_I), .SLEEP_I(SLEEP_I),
  .SLEEP_OUTPUT_OPTION_I(SLEEP_OUTPUT_OPTION_I), .CLAMP_WINDOW_TRIM_I(CLAMP_WINDOW_TRIM_I),
  .FORMAT_O(FORMAT_O), .VBI_READY_FLAGS_O(VBI_READY_FLAGS_O),
  .CLAMP_START_SHIFT_O(CLAMP_START_SHIFT_O), .LUMA_OE_O(LUMA_OE_O), .CHROMA_OE_O(CHROMA_OE_O),
  .BLUE_OE_O(BLUE_OE_O), .AUX_HIGH_OE_O(AUX_HIGH_OE_O), .AUX_LOW_OE_O(AUX_LOW_OE_O),
  .SYNC_OE_O(SYNC_OE_O), .VALID_OE_O(VALID_OE_O), .STATUS_OE_O(STATUS_OE_O));
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the vbi readback block
`default_nettype none
module tb_top
  import vrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata, trim, shift, flags;
  logic wr, rd, rvalid, store, int_mode, sleep, opt;
  logic [1:0] mode_pin, int_fmt, fmt;
  logic [15:0] cc_o, cc_e;
  logic [19:0] cg_o, cg_e;
  logic [12:0] ws;
  logic luma, chroma, blue, auxh, auxl, sync, valid, stat;
  logic [7:0] oe_seen;
  assign oe_seen = {luma, chroma, blue, auxh, auxl, sync, valid, stat};
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] exp_b [12] = '{8'h5A, 8'hA5, 8'hC3, 8'h3C, 8'hCB, 8'hED, 8'h0F, 8'h45,
    8'h23, 8'h01, 8'hBC, 8'h1A};
  // 100 MHz clock
  always #5 clk = ~clk;
  vrb_top dut_u (
    .CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .CAPTION_ODD_STORE_I(store), .CAPTION_ODD_DATA_I(cc_o),
    .CAPTION_EVEN_STORE_I(store), .CAPTION_EVEN_DATA_I(cc_e),
    .COPYGUARD_ODD_STORE_I(store), .COPYGUARD_ODD_DATA_I(cg_o),
    .COPYGUARD_EVEN_STORE_I(store), .COPYGUARD_EVEN_DATA_I(cg_e),
    .WIDESCREEN_STORE_I(store), .WIDESCREEN_DATA_I(ws), .MODE_PIN_I(mode_pin),
    .INTERNAL_REG_MODE_I(int_mode), .INTERNAL_FORMAT_SELECT_I(int_fmt), .SLEEP_I(sleep),
    .SLEEP_OUTPUT_OPTION_I(opt), .CLAMP_WINDOW_TRIM_I(trim), .FORMAT_O(fmt),
    .VBI_READY_FLAGS_O(flags), .CLAMP_START_SHIFT_O(shift), .LUMA_OE_O(luma),
    .CHROMA_OE_O(chroma), .BLUE_OE_O(blue), .AUX_HIGH_OE_O(auxh), .AUX_LOW_OE_O(auxl),
    .SYNC_OE_O(sync), .VALID_OE_O(valid), .STATUS_OE_O(stat));
  vrb_host host_u (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
  // one compare for every byte-sized result
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    cmp_count++;
    if (got !== ex) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(nm, ex, d);
  endtask
  // expected enables {luma,chroma,blue,auxh,auxl,sync,valid,status}; s: 0 run, 1/2 sleep opt
  function automatic logic [7:0] exp_oe(input int f, input int s, input int t);
    logic l, c, b, a, y;
    {l, c, b, a, y} = 5'h1F;
    if (s == 2) {l, c, b, a, y} = 5'h00;
    else if (s == 1) begin
      b = (f == 3);
      c = (f >= 2);
    end else if (t == 1) {l, c, b, a} = 4'h0;
    else if (t == 2) {l, c, b, a, y} = 5'h00;
    else if (f != 3) {c, b} = 2'h0;
    return {l, c, b, a, 1'b1, y, y, y};
  endfunction
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    store = 1'b0;
    cc_o = 16'hA55A;
    cc_e = 16'h3CC3;
    cg_o = 20'hFEDCB;
    cg_e = 20'h12345;
    ws = 13'h1ABC;
    mode_pin = 2'h0;
    int_mode = 1'b1;
    int_fmt = 2'h0;
    sleep = 1'b0;
    opt = 1'b0;
    trim = 8'h00;
    tick(20);
    rst_n = 1'b1;
    tick(3);
    rdchk("flags_reset", OFS_READY_FLAGS, 8'h00);
    rdchk("ctrl_read", OFS_TRISTATE_CTRL, 8'h00);
    rdchk("unmapped", 8'h40, 8'h00);
    // all five sources stored in one pulse
    store = 1'b1;
    tick(1);
    store = 1'b0;
    rdchk("flags_set", OFS_READY_FLAGS, 8'h79);
    for (int i = 0; i < 12; i++) begin
      rdchk("buffer", OFS_CAPTION_ODD_LOW + 8'(i), exp_b[i]);
    end
    host_u.wr(OFS_CAPTION_ODD_LOW, 8'hFF);
    rdchk("buffer_wr", OFS_CAPTION_ODD_LOW, 8'h5A);
    host_u.wr(OFS_FLAG_CLEAR, 8'h40);
    rdchk("flags_one_clear", OFS_READY_FLAGS, 8'h39);
    host_u.wr(OFS_FLAG_CLEAR, 8'h79);
    rdchk("flags_clear", OFS_READY_FLAGS, 8'h00);
    for (int t = 0; t < 3; t++) begin
      host_u.wr(OFS_TRISTATE_CTRL, 8'(t));
      for (int f = 0; f < 4; f++) begin
        for (int s = 0; s < 3; s++) begin
          int_fmt = 2'(f);
          sleep = (s != 0);
          opt = (s == 2);
          tick(3);
          chk("oe", exp_oe(f, s, t), oe_seen);
          chk("format", 8'(f), {6'h00, fmt});
        end
      end
    end
    // external pins take over outside register mode
    int_mode = 1'b0;
    int_fmt = 2'h1;
    mode_pin = 2'h2;
    tick(4);
    chk("ext_format", 8'h02, {6'h00, fmt});
    for (int n = 0; n < 16; n++) begin
      trim = {4'(n), 4'h5};
      tick(2);
      chk("clamp", 8'(n < 12 ? n * 8 : n * 8 - 128), shift);
    end
    summarize();
  end
endmodule
`default_nettype wire
